// File: therm_pkg.sv
// Shared constants for the bus-powered thermometer and its bus master
package therm_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int T_CONV_MS = 750;
  localparam int T_COPY_MS = 10;
  localparam int T_SPU_US = 10;
  localparam int CONV_CYCLES = T_CONV_MS * (CLK_HZ / 1000);
  localparam int COPY_CYCLES = T_COPY_MS * (CLK_HZ / 1000);
  localparam int SPU_CYCLES = T_SPU_US * (CLK_HZ / 1_000_000);
  localparam int CNT_W = 27;
  localparam int HOLDUP_W = 6;
  localparam int RSP_TIMEOUT = 16;

  // ----------------------------------------------------------------
  // Commands and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_CONVERT = 8'h44;
  localparam logic [7:0] CMD_COPY = 8'h48;
  localparam logic [7:0] CMD_WRITE_CFG = 8'h4e;
  localparam logic [7:0] CMD_READ = 8'hbe;
  localparam int CFG_RES_LOW_POS = 5;
  localparam int CFG_RES_HIGH_POS = 6;
  localparam int SIGN_POS = 11;
  localparam logic [15:0] TEMP_RESET = 16'h0550;
  localparam logic [1:0] RES_RESET = 2'h3;
  localparam logic [1:0] RES_12BIT = 2'h3;

  // ----------------------------------------------------------------
  // Master register map (Avalon byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_ROM_LO = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_ROM_HI = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h0c;
  localparam logic [ADDR_W-1:0] ADDR_TEMP = 5'h10;
  localparam int CTRL_CODE_POS = 0;
  localparam int CTRL_DATA_POS = 8;
  localparam int ST_BUSY_POS = 0;
  localparam int ST_SPU_POS = 1;
  localparam int ST_PRESENT_POS = 2;
  localparam int ST_TEMP_VALID_POS = 3;
  localparam int ST_TIMEOUT_POS = 4;
endpackage : therm_pkg

// File: therm_link_if.sv
// Single-line bus between thermometer and master, with decoded command channel
interface therm_link_if;
  logic cmd_valid;
  logic [7:0] cmd_code;
  logic [7:0] cmd_data;
  logic [63:0] cmd_rom;
  logic rsp_valid;
  logic [15:0] rsp_data;
  logic master_low_oe;
  logic device_low_oe;
  logic strong_pullup_oe;
  logic line_level;

  // Strong pullup dominates; otherwise weak pullup unless someone pulls low
  assign line_level = strong_pullup_oe | ~(master_low_oe | device_low_oe);

  modport master(
    output cmd_valid, cmd_code, cmd_data, cmd_rom, master_low_oe, strong_pullup_oe,
    input rsp_valid, rsp_data, line_level
  );
  modport device(
    input cmd_valid, cmd_code, cmd_data, cmd_rom, line_level,
    output rsp_valid, rsp_data, device_low_oe
  );
endinterface : therm_link_if

// File: therm_device.sv
// Bus-powered thermometer: command decode, conversion timing and result register
module therm_device
  import therm_pkg::*;
#(
  parameter int CONV_CYCLES_P = CONV_CYCLES,
  parameter int COPY_CYCLES_P = COPY_CYCLES,
  parameter logic [63:0] DEVICE_CODE = 64'h0123_4567_89ab_cdef // Arbitrary value
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  therm_link_if.device link,
  input wire logic [11:0] sensor_temp,
  output logic [15:0] measured_temperature,
  output logic converting,
  output logic copying,
  output logic resolution_sel_low,
  output logic resolution_sel_high,
  output logic power_fault
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  initial begin
    if (CONV_CYCLES_P < 8 || CONV_CYCLES_P >= (1 << CNT_W)) begin
      $error("CONV_CYCLES_P out of range");
    end
    if (COPY_CYCLES_P < 1 || COPY_CYCLES_P >= (1 << CNT_W)) begin
      $error("COPY_CYCLES_P out of range");
    end
  end

  localparam logic [CNT_W-1:0] CONV_LEN = CNT_W'(CONV_CYCLES_P);
  localparam logic [CNT_W-1:0] COPY_LEN = CNT_W'(COPY_CYCLES_P);
  localparam logic [HOLDUP_W-1:0] HOLDUP_FULL = '1;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DEV_IDLE,
    DEV_CONVERT,
    DEV_COPY
  } dev_mode_t;

  typedef struct packed {
    dev_mode_t mode;
    logic [CNT_W-1:0] count;
    logic [15:0] temp;
    logic [1:0] res;
    logic [HOLDUP_W-1:0] hold_up_capacitor;
    logic fault;
    logic present;
    logic rsp_valid;
    logic [15:0] rsp_data;
  } dev_state_t;

  dev_state_t s;
  dev_state_t next_s;

  logic selected;
  logic [1:0] shift;
  logic [CNT_W-1:0] conv_len;
  logic [15:0] valid_mask;
  logic [15:0] sample;
  logic brownout;

  always_comb begin
    selected = link.cmd_valid && (link.cmd_rom == DEVICE_CODE);
    shift = 2'h3 - s.res;
    conv_len = CONV_LEN >> shift;
    // Undefined low bits read as zero so results compare cleanly
    valid_mask = 16'hffff << shift;
    // Sensor word is already in 1/16 degree centigrade steps
    sample = {{5{sensor_temp[SIGN_POS]}}, sensor_temp[10:0]} & valid_mask;
    // The hold-up store cannot carry a conversion once it is empty and the line is low
    brownout = (s.mode != DEV_IDLE) && !link.line_level && !s.present && (s.hold_up_capacitor == '0);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.present = 1'b0;
    next_s.rsp_valid = 1'b0;
    // Charge while the line is high, drain while it is low
    if (link.line_level) begin
      if (s.hold_up_capacitor != HOLDUP_FULL) begin
        next_s.hold_up_capacitor = s.hold_up_capacitor + 1'b1;
      end
    end else if (s.hold_up_capacitor != '0) begin
      next_s.hold_up_capacitor = s.hold_up_capacitor - 1'b1;
    end
    unique case (s.mode)
      DEV_IDLE: begin
        if (selected) begin
          next_s.present = 1'b1;
          if (link.cmd_code == CMD_CONVERT) begin
            next_s.mode = DEV_CONVERT;
            next_s.count = conv_len - 1'b1;
            next_s.fault = 1'b0;
          end else if (link.cmd_code == CMD_COPY) begin
            next_s.mode = DEV_COPY;
            next_s.count = COPY_LEN - 1'b1;
            next_s.fault = 1'b0;
          end else if (link.cmd_code == CMD_WRITE_CFG) begin
            next_s.res = {link.cmd_data[CFG_RES_HIGH_POS], link.cmd_data[CFG_RES_LOW_POS]};
          end else if (link.cmd_code == CMD_READ) begin
            next_s.rsp_valid = 1'b1;
            next_s.rsp_data = s.temp;
          end
        end
      end
      DEV_CONVERT: begin
        if (brownout) begin
          // Aborted conversion keeps the old result
          next_s.fault = 1'b1;
          next_s.mode = DEV_IDLE;
        end else if (s.count == '0) begin
          next_s.temp = sample;
          next_s.mode = DEV_IDLE;
        end else begin
          next_s.count = s.count - 1'b1;
        end
      end
      DEV_COPY: begin
        if (brownout) begin
          next_s.fault = 1'b1;
          next_s.mode = DEV_IDLE;
        end else if (s.count == '0) begin
          next_s.mode = DEV_IDLE;
        end else begin
          next_s.count = s.count - 1'b1;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s.mode <= DEV_IDLE;
      s.count <= '0;
      s.temp <= TEMP_RESET;
      s.res <= RES_RESET;
      s.hold_up_capacitor <= '0;
      s.fault <= 1'b0;
      s.present <= 1'b0;
      s.rsp_valid <= 1'b0;
      s.rsp_data <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Only ever pulls low; the high level comes from the pullups
  assign link.device_low_oe = s.present;
  assign link.rsp_valid = s.rsp_valid;
  assign link.rsp_data = s.rsp_data;
  assign measured_temperature = s.temp;
  assign converting = (s.mode == DEV_CONVERT);
  assign copying = (s.mode == DEV_COPY);
  assign resolution_sel_low = s.res[0];
  assign resolution_sel_high = s.res[1];
  assign power_fault = s.fault;

endmodule : therm_device

// File: therm_master.sv
// Bus master for the thermometer, driven through Avalon-MM registers
module therm_master
  import therm_pkg::*;
#(
  parameter int CONV_CYCLES_P = CONV_CYCLES,
  parameter int COPY_CYCLES_P = COPY_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  therm_link_if.master link
);

  initial begin
    if (CONV_CYCLES_P < 8 || CONV_CYCLES_P >= (1 << CNT_W)) begin
      $error("CONV_CYCLES_P out of range");
    end
    if (COPY_CYCLES_P < 1 || COPY_CYCLES_P >= (1 << CNT_W)) begin
      $error("COPY_CYCLES_P out of range");
    end
  end

  localparam logic [CNT_W-1:0] CONV_LEN = CNT_W'(CONV_CYCLES_P);
  localparam logic [CNT_W-1:0] COPY_LEN = CNT_W'(COPY_CYCLES_P);
  localparam logic [CNT_W-1:0] RSP_LEN = CNT_W'(RSP_TIMEOUT);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    M_IDLE,
    M_SEND,
    M_HOLD,
    M_WAIT_RSP
  } m_mode_t;

  typedef struct packed {
    m_mode_t mode;
    logic [CNT_W-1:0] count;
    logic [7:0] code;
    logic [7:0] data;
    logic [63:0] rom;
    logic [1:0] res;
    logic spu;
    logic present;
    logic temp_valid;
    logic timeout;
    logic [15:0] temp;
    logic ack;
    logic [31:0] rdata;
  } m_state_t;

  m_state_t s;
  m_state_t next_s;
  logic take;
  logic [31:0] rmux;

  always_comb begin
    take = (avs_read || avs_write) && s.ack;
    rmux = 32'h0000_0000;
    unique case (avs_address)
      ADDR_CTRL: rmux = {16'h0000, s.data, s.code};
      ADDR_ROM_LO: rmux = s.rom[31:0];
      ADDR_ROM_HI: rmux = s.rom[63:32];
      ADDR_STATUS: rmux = {27'h0, s.timeout, s.temp_valid, s.present, s.spu, s.mode != M_IDLE};
      ADDR_TEMP: rmux = {16'h0000, s.temp};
      default: rmux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    next_s = s;
    // One wait cycle: read data is loaded, then shown with waitrequest low
    next_s.ack = (avs_read || avs_write) && !s.ack;
    if ((avs_read || avs_write) && !s.ack) begin
      next_s.rdata = rmux;
    end
    if (take && avs_write) begin
      unique case (avs_address)
        ADDR_ROM_LO: next_s.rom[31:0] = avs_writedata;
        ADDR_ROM_HI: next_s.rom[63:32] = avs_writedata;
        ADDR_CTRL: begin
          // Orders while busy are dropped: the line must stay quiet
          if (s.mode == M_IDLE) begin
            next_s.code = avs_writedata[CTRL_CODE_POS +: 8];
            next_s.data = avs_writedata[CTRL_DATA_POS +: 8];
            next_s.mode = M_SEND;
            next_s.present = 1'b0;
            next_s.timeout = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    unique case (s.mode)
      M_IDLE: begin
      end
      M_SEND: begin
        if (link.line_level == 1'b0 || s.code != CMD_READ) begin
          next_s.present = 1'b1;
        end
        if (s.code == CMD_CONVERT) begin
          next_s.spu = 1'b1;
          next_s.mode = M_HOLD;
          next_s.count = (CONV_LEN >> (2'h3 - s.res)) - 1'b1;
        end else if (s.code == CMD_COPY) begin
          next_s.spu = 1'b1;
          next_s.mode = M_HOLD;
          next_s.count = COPY_LEN - 1'b1;
        end else if (s.code == CMD_READ) begin
          next_s.mode = M_WAIT_RSP;
          next_s.count = RSP_LEN - 1'b1;
        end else begin
          if (s.code == CMD_WRITE_CFG) begin
            next_s.res = {s.data[CFG_RES_HIGH_POS], s.data[CFG_RES_LOW_POS]};
          end
          next_s.mode = M_IDLE;
        end
      end
      M_HOLD: begin
        if (s.count == '0) begin
          next_s.spu = 1'b0;
          next_s.mode = M_IDLE;
        end else begin
          next_s.count = s.count - 1'b1;
        end
      end
      M_WAIT_RSP: begin
        if (link.rsp_valid) begin
          next_s.temp = link.rsp_data;
          next_s.temp_valid = 1'b1;
          next_s.present = 1'b1;
          next_s.mode = M_IDLE;
        end else if (s.count == '0) begin
          next_s.timeout = 1'b1;
          next_s.mode = M_IDLE;
        end else begin
          next_s.count = s.count - 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s.mode <= M_IDLE;
      s.count <= '0;
      s.code <= '0;
      s.data <= '0;
      s.rom <= '0;
      s.res <= RES_RESET;
      s.spu <= 1'b0;
      s.present <= 1'b0;
      s.temp_valid <= 1'b0;
      s.timeout <= 1'b0;
      s.temp <= '0;
      s.ack <= 1'b0;
      s.rdata <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !s.ack;
  assign avs_readdata = s.rdata;
  assign link.cmd_valid = (s.mode == M_SEND);
  assign link.cmd_code = s.code;
  assign link.cmd_data = s.data;
  assign link.cmd_rom = s.rom;
  // Command signalling pull; never while the strong pullup is on
  assign link.master_low_oe = (s.mode == M_SEND) && !s.spu;
  assign link.strong_pullup_oe = s.spu;

endmodule : therm_master

// File: therm_link_assertions.sv
// Concurrent checks on the link between thermometer and master
module therm_link_assertions
  import therm_pkg::*;
#(
  parameter int CONV_CYCLES_P = 64,
  parameter int COPY_CYCLES_P = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic master_low_oe,
  input wire logic device_low_oe,
  input wire logic strong_pullup_oe
);
  // Longest pullup hold, one cycle of slack for the registered drop
  localparam int SPU_MAX = (CONV_CYCLES_P > COPY_CYCLES_P ? CONV_CYCLES_P : COPY_CYCLES_P) + 1;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // Strong pullup
  // ----------------------------------------------------------------
  spu_start_a: assert property (cmd_valid && (cmd_code == CMD_CONVERT || cmd_code == CMD_COPY)
    |=> strong_pullup_oe) else $error("strong pullup late");
  spu_hold_a: assert property ($rose(strong_pullup_oe) |-> strong_pullup_oe [*8])
    else $error("strong pullup dropped early");
  spu_quiet_a: assert property (strong_pullup_oe |-> !cmd_valid && !master_low_oe)
    else $error("bus activity under strong pullup");
  spu_end_a: assert property ($rose(strong_pullup_oe) |-> ##[8:SPU_MAX] !strong_pullup_oe)
    else $error("strong pullup held too long");
  // ----------------------------------------------------------------
  // Device answers
  // ----------------------------------------------------------------
  pull_cause_a: assert property ($rose(device_low_oe) |-> $past(cmd_valid))
    else $error("device pulled low unprompted");
  pull_brief_a: assert property (device_low_oe |=> !device_low_oe)
    else $error("device held line low");
  rsp_cause_a: assert property (rsp_valid |-> $past(cmd_valid) && $past(cmd_code) == CMD_READ)
    else $error("response without read");
  sign_ext_a: assert property (rsp_valid |-> rsp_data[15:11] == 5'h00 || rsp_data[15:11] == 5'h1f)
    else $error("sign bits differ");
endmodule : therm_link_assertions

// File: parasite_temp_conversion_tb.sv
// Testbench joining thermometer and master over the link
module parasite_temp_conversion_tb;
  import therm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CONV = 64;
  localparam int COPY = 16;
  localparam logic [63:0] CODE = 64'h5a5a_1234_c3c3_0f0f; // Arbitrary value
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [11:0] sensor_temp = '0;
  logic [15:0] measured_temperature;
  logic converting, copying, resolution_sel_low, resolution_sel_high, power_fault;
  int conv_seen = 0;
  int copy_seen = 0;
  int base = 0;
  logic [31:0] rd;
  logic [15:0] keep;
  int n_mismatch = 0;
  int n_tests = 0;
  int seed = 10302;
  logic [11:0] tbl_in [4] = '{12'h191, 12'he6f, 12'hc90, 12'hff8};
  logic [15:0] tbl_out [4] = '{16'h0191, 16'hfe6f, 16'hfc90, 16'hfff8};
  therm_link_if link();
  therm_device #(.CONV_CYCLES_P(CONV), .COPY_CYCLES_P(COPY), .DEVICE_CODE(CODE)) therm_device_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .link(link.device), .sensor_temp(sensor_temp),
    .measured_temperature(measured_temperature), .converting(converting), .copying(copying),
    .resolution_sel_low(resolution_sel_low), .resolution_sel_high(resolution_sel_high), .power_fault(power_fault));
  therm_master #(.CONV_CYCLES_P(CONV), .COPY_CYCLES_P(COPY)) therm_master_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .link(link.master));
  therm_link_assertions #(.CONV_CYCLES_P(CONV), .COPY_CYCLES_P(COPY)) therm_link_assertions_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code),
    .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data), .master_low_oe(link.master_low_oe),
    .device_low_oe(link.device_low_oe), .strong_pullup_oe(link.strong_pullup_oe));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // Busy cycles are counted, never cleared, so only this process writes them
  always @(posedge ref_clk) begin
    if (converting === 1'b1) conv_seen <= conv_seen + 1;
    if (copying === 1'b1) copy_seen <= copy_seen + 1;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  // One idle edge after release, so a following request never lands in the same step
  task automatic av_xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    rd = avs_readdata;
    if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask : av_xfer
  task automatic wait_idle;
    int n;
    n = 0;
    rd = 32'h1;
    while (rd[ST_BUSY_POS] !== 1'b0 && n < 200) begin
      av_xfer(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end
    if (n >= 200) chk("busy", 32'h0, 32'h1);
  endtask : wait_idle
  function automatic logic [15:0] expect_temp(input logic [11:0] t, input logic [1:0] r);
    return {{4{t[11]}}, t} & ~(16'h0007 >> r);
  endfunction : expect_temp
  task automatic set_res(input logic [1:0] r);
    av_xfer(1'b1, ADDR_CTRL, {16'h0, 1'b0, r, 5'h00, CMD_WRITE_CFG});
    wait_idle();
    chk("resolution", r, {resolution_sel_high, resolution_sel_low});
  endtask : set_res
  task automatic convert(input logic [11:0] t, input logic [1:0] r, input logic [15:0] exp);
    int n;
    n = 0;
    sensor_temp <= t;
    av_xfer(1'b1, ADDR_CTRL, {24'h0, CMD_CONVERT});
    do begin
      @(posedge ref_clk);
      n++;
    end while (converting === 1'b1 && n < 200);
    chk("conv length", 32'h1, (n >= (CONV >> (3 - r)) && n <= (CONV >> (3 - r)) + 1));
    wait_idle();
    chk("result", exp, measured_temperature);
    av_xfer(1'b1, ADDR_CTRL, {24'h0, CMD_READ});
    wait_idle();
    chk("temp valid", 32'h1, rd[ST_TEMP_VALID_POS]);
    av_xfer(1'b0, ADDR_TEMP, 32'h0);
    chk("temp read", exp, rd[15:0]);
  endtask : convert
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [1:0] r;
    logic [11:0] t;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk("reset temp", TEMP_RESET, measured_temperature);
    chk("reset res", RES_RESET, {resolution_sel_high, resolution_sel_low});
    chk("reset idle", 32'h0, converting);
    av_xfer(1'b1, ADDR_ROM_LO, CODE[31:0]);
    av_xfer(1'b1, ADDR_ROM_HI, CODE[63:32]);
    av_xfer(1'b0, ADDR_ROM_HI, 32'h0);
    chk("rom high", CODE[63:32], rd);
    av_xfer(1'b1, 5'h14, 32'hffff_ffff);
    av_xfer(1'b0, 5'h14, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("test reset and map done");
    // Default resolution must already give full-length conversions
    for (int i = 0; i < 4; i++) convert(tbl_in[i], 2'h3, tbl_out[i]);
    for (int i = 0; i < 10; i++) begin
      r = i < 4 ? i[1:0] : 2'($random(seed));
      t = 12'($random(seed));
      set_res(r);
      convert(t, r, expect_temp(t, r));
    end
    $display("test conversions done");
    keep = measured_temperature;
    base = copy_seen;
    av_xfer(1'b1, ADDR_CTRL, {24'h0, CMD_CONVERT});
    av_xfer(1'b1, ADDR_CTRL, {24'h0, CMD_COPY});
    wait_idle();
    chk("copy while busy", 32'h0, copy_seen - base);
    keep = measured_temperature;
    base = copy_seen;
    av_xfer(1'b1, ADDR_CTRL, {24'h0, CMD_COPY});
    wait_idle();
    chk("copy length", COPY, copy_seen - base);
    chk("copy keeps temp", keep, measured_temperature);
    $display("test copy done");
    base = conv_seen;
    sensor_temp <= ~sensor_temp;
    av_xfer(1'b1, ADDR_ROM_LO, ~CODE[31:0]);
    av_xfer(1'b1, ADDR_CTRL, {24'h0, CMD_CONVERT});
    wait_idle();
    chk("foreign code", 32'h0, conv_seen - base);
    chk("foreign keeps temp", keep, measured_temperature);
    chk("no power fault", 32'h0, power_fault);
    // Nobody answers a foreign code, so the master must give up on its own
    av_xfer(1'b1, ADDR_CTRL, {24'h0, CMD_READ});
    wait_idle();
    chk("read timeout", 32'h1, rd[ST_TIMEOUT_POS]);
    $display("test addressing done");
    av_xfer(1'b1, ADDR_ROM_LO, CODE[31:0]);
    set_res(2'h1);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk("rearm res", RES_RESET, {resolution_sel_high, resolution_sel_low});
    chk("rearm temp", TEMP_RESET, measured_temperature);
    $display("test second reset done");
    report_and_stop();
  end
  initial begin
    #400000;
    n_mismatch++;
    report_and_stop();
  end
endmodule : parasite_temp_conversion_tb
